// file: rtl/hbu_pkg.sv
// Package of constants and carrier types for the hardware breakpoint unit
// Overview of operation
// - Two instruction and two data breakpoint registers, 32 bits, software accessible.
// - Enabled instruction match requests exception before the matching instruction executes.
// - Stored value compared directly with modified virtual address; no identifier merge.
// - Word state compares upper 30 bits; compressed state compares upper 31 bits.
// - Bit 0 of each instruction register enables its comparator.
// - Instruction breakpoint writes entry cause code 001.
// - Control bit 8 selects second data register as comparator or mask.
// - First enable bits 1:0: off, stores, any, loads.
// - Second enable bits 3:2 same encoding; ignored in mask role.
// - Mask role excludes set bits from first compare, only while first enabled.
// - Comparator role: second register matches independently by own enable.
// - Data hit when type enabled and any covered byte matches address.
// - Preload hints and coprocessor maintenance registers 7 to 10 never hit.
// - Swap and swap byte count as stores.
// - Unaligned word and larger accesses compare the address rounded down to a word.
// - Data hit does not abort access; reported after issue, before next instruction.
// - Data breakpoint writes entry cause code 010.
// - Data breakpoint link value is next instruction address plus 4.
// - Software breakpoint is a no-op unless global debug enable is set.
// - Monitor handling routes data hits as data aborts, others as prefetch aborts.
// - Data breakpoint ranks priority 4, instruction breakpoint priority 9.
package hbu_pkg;
    localparam logic [31:0] IBC0_OFS = 32'h0000_0000;
    localparam logic [31:0] IBC1_OFS = 32'h0000_0004;
    localparam logic [31:0] DBA0_OFS = 32'h0000_0008;
    localparam logic [31:0] DBA1_OFS = 32'h0000_000C;
    localparam logic [31:0] DBCTL_OFS = 32'h0000_0010;
    localparam logic [31:0] DBCTL_MASK = 32'h0000_010F;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam int IB_EN_BIT = 0;
    localparam int DB_ROLE_BIT = 8;
    localparam int DB_FIRST_EN_LSB = 0;
    localparam int DB_SECOND_EN_LSB = 2;
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_IBRK = 3'h1;
    localparam logic [2:0] CAUSE_DBRK = 3'h2;
    localparam logic [2:0] CAUSE_SBRK = 3'h3;
    localparam logic [3:0] PRIO_DBRK = 4'h4;
    localparam logic [3:0] PRIO_IBRK = 4'h9;
    localparam logic [3:0] PRIO_SBRK = 4'hB;
    localparam logic [31:0] LINK_OFS = 32'h0000_0004;
    localparam logic [3:0] CP_FIRST_MAINT = 4'h7;
    localparam logic [3:0] CP_LAST_MAINT = 4'hA;

    typedef enum logic [1:0] {
        HBU_ACC_OFF = 2'b00,
        HBU_ACC_STORE = 2'b01,
        HBU_ACC_ANY = 2'b10,
        HBU_ACC_LOAD = 2'b11
    } hbu_acc_e;

    // Data access offered by the load/store unit
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [2:0] size;
        logic is_store;
        logic is_swap;
        logic is_preload;
        logic is_cp_maint;
        logic [3:0] cp_reg;
        logic [31:0] next_pc;
    } hbu_dacc_s;

    // Exception request towards the core
    typedef struct packed {
        logic req;
        logic [2:0] cause;
        logic [3:0] prio;
        logic as_data_abort;
        logic as_prefetch_abort;
        logic [31:0] link;
    } hbu_exc_s;
endpackage

// file: rtl/hbu_top.sv
// Hardware breakpoint unit with AHB-Lite register slave
module hbu_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic global_debug_enable,
    input wire logic monitor_mode,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic compressed_state,
    input wire logic sw_break_valid,
    input wire hbu_pkg::hbu_dacc_s dacc,
    output hbu_pkg::hbu_exc_s instr_exc,
    output hbu_pkg::hbu_exc_s data_exc,
    output logic [2:0] entry_cause,
    output logic sw_break_nop
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage and bus slave
    logic [31:0] ibc_reg [2];
    logic [31:0] dba0_reg;
    logic [31:0] dba1_reg;
    logic [31:0] dbctl_reg;
    logic wr_pend_reg;
    logic [31:0] wr_addr_reg;
    logic [31:0] rdata_next;

    wire logic addr_phase = hsel && hready && htrans[1];

    // Word offset to register index, shared by the read and write paths
    function automatic logic [2:0] reg_index(input logic [31:0] a);
        case ({a[31:2], 2'b00})
            hbu_pkg::IBC0_OFS: reg_index = 3'h0;
            hbu_pkg::IBC1_OFS: reg_index = 3'h1;
            hbu_pkg::DBA0_OFS: reg_index = 3'h2;
            hbu_pkg::DBA1_OFS: reg_index = 3'h3;
            hbu_pkg::DBCTL_OFS: reg_index = 3'h4;
            default: reg_index = 3'h7;
        endcase
    endfunction

    // Read multiplexer over the map; unmapped words read zero
    function automatic logic [31:0] rd_mux(input logic [31:0] a, input logic [31:0] i0,
                                           input logic [31:0] i1, input logic [31:0] d0,
                                           input logic [31:0] d1, input logic [31:0] dc);
        case (reg_index(a))
            3'h0: rd_mux = i0;
            3'h1: rd_mux = i1;
            3'h2: rd_mux = d0;
            3'h3: rd_mux = d1;
            3'h4: rd_mux = dc;
            default: rd_mux = hbu_pkg::REG_RESET;
        endcase
    endfunction

    // Write address latched in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= hbu_pkg::REG_RESET;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr;
            end
        end
    end

    // Register writes in the data phase; all registers are software accessible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ibc_reg[0] <= hbu_pkg::REG_RESET;
            ibc_reg[1] <= hbu_pkg::REG_RESET;
            dba0_reg <= hbu_pkg::REG_RESET;
            dba1_reg <= hbu_pkg::REG_RESET;
            dbctl_reg <= hbu_pkg::REG_RESET;
        end else if (wr_pend_reg) begin
            case (reg_index(wr_addr_reg))
                3'h0: ibc_reg[0] <= hwdata;
                3'h1: ibc_reg[1] <= hwdata;
                3'h2: dba0_reg <= hwdata;
                3'h3: dba1_reg <= hwdata;
                3'h4: dbctl_reg <= hwdata & hbu_pkg::DBCTL_MASK;
                default: dbctl_reg <= dbctl_reg;
            endcase
        end
    end

    // Read data prepared from the address phase
    always_comb begin
        rdata_next = rd_mux(haddr, ibc_reg[0], ibc_reg[1], dba0_reg, dba1_reg, dbctl_reg);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= hbu_pkg::REG_RESET;
        end else if (addr_phase && !hwrite) begin
            hrdata <= rdata_next;
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Reserved control bits always read back as zero
    property p_rd_ctl;
        @(posedge hclk) disable iff (!hresetn)
        (addr_phase && !hwrite && haddr == hbu_pkg::DBCTL_OFS) |=>
        (hrdata & ~hbu_pkg::DBCTL_MASK) == hbu_pkg::REG_RESET;
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("control reserved bits");

    ////////////////////////////////////////////////////////////////////////
    // Instruction comparators
    logic [1:0] ib_hit;

    // Address compare in the current instruction state; stored value used as written
    function automatic logic ib_match(input logic [31:0] bp, input logic [31:0] pc,
                                      input logic half);
        if (half) begin
            ib_match = bp[31:1] == pc[31:1];
        end else begin
            ib_match = bp[31:2] == pc[31:2];
        end
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ib
            assign ib_hit[gi] = fetch_valid && ibc_reg[gi][hbu_pkg::IB_EN_BIT] &&
                                ib_match(ibc_reg[gi], fetch_addr, compressed_state);
        end
    endgenerate

    // Halfword state breaks on the halfword address
    property p_ib_half;
        @(posedge hclk) disable iff (!hresetn)
        (fetch_valid && ibc_reg[1][0] && compressed_state && ibc_reg[1][31:1] == fetch_addr[31:1])
        |=> instr_exc.req && instr_exc.cause == hbu_pkg::CAUSE_IBRK;
    endproperty
    a_ib_half: assert property (p_ib_half) else $error("halfword hit missed");

    ////////////////////////////////////////////////////////////////////////
    // Data comparators
    logic [1:0] first_comparator_enable;
    logic [1:0] second_comparator_enable;
    logic mask_role;
    logic eligible;
    logic store_like;
    logic [31:0] word_addr;
    logic [31:0] last_byte;
    logic [31:0] mask0;
    logic d0_hit;
    logic d1_hit;

    // Access type check shared by both comparators
    function automatic logic type_ok(input logic [1:0] en, input logic st);
        case (en)
            hbu_pkg::HBU_ACC_STORE: type_ok = st;
            hbu_pkg::HBU_ACC_ANY: type_ok = 1'b1;
            hbu_pkg::HBU_ACC_LOAD: type_ok = !st;
            default: type_ok = 1'b0;
        endcase
    endfunction

    // Byte range check: any byte of the access equal to the target
    function automatic logic in_range(input logic [31:0] lo, input logic [31:0] hi,
                                      input logic [31:0] tgt, input logic [31:0] m);
        in_range = ((lo & ~m) <= (tgt & ~m)) && ((tgt & ~m) <= (hi & ~m));
    endfunction

    always_comb begin
        first_comparator_enable = dbctl_reg[hbu_pkg::DB_FIRST_EN_LSB +: 2];
        second_comparator_enable = dbctl_reg[hbu_pkg::DB_SECOND_EN_LSB +: 2];
        mask_role = dbctl_reg[hbu_pkg::DB_ROLE_BIT];
        store_like = dacc.is_store || dacc.is_swap;
        eligible = dacc.valid && !dacc.is_preload &&
                   !(dacc.is_cp_maint && dacc.cp_reg >= hbu_pkg::CP_FIRST_MAINT &&
                     dacc.cp_reg <= hbu_pkg::CP_LAST_MAINT);
        word_addr = (dacc.addr[1:0] != 2'b00 && dacc.size >= 3'd2) ?
                    {dacc.addr[31:2], 2'b00} : dacc.addr;
        last_byte = word_addr + ((32'h0000_0001 << dacc.size) - 32'h0000_0001);
        mask0 = mask_role ? dba1_reg : hbu_pkg::REG_RESET;
        d0_hit = eligible && type_ok(first_comparator_enable, store_like) &&
                 in_range(word_addr, last_byte, dba0_reg, mask0);
        d1_hit = eligible && !mask_role && type_ok(second_comparator_enable, store_like) &&
                 in_range(word_addr, last_byte, dba1_reg, hbu_pkg::REG_RESET);
    end

    // Data requests only follow an offered access
    property p_d_idle;
        @(posedge hclk) disable iff (!hresetn)
        !dacc.valid |=> !data_exc.req;
    endproperty
    a_d_idle: assert property (p_d_idle) else $error("data request unprompted");

    // Second comparator in its own role catches a store to its address
    property p_d1_indep;
        @(posedge hclk) disable iff (!hresetn)
        (dacc.valid && dacc.is_store && !dacc.is_preload && !dacc.is_cp_maint && !mask_role &&
         second_comparator_enable == hbu_pkg::HBU_ACC_STORE && dacc.addr == dba1_reg &&
         dacc.addr[1:0] == 2'b00 && dacc.size <= 3'd2) |=> data_exc.req;
    endproperty
    a_d1_indep: assert property (p_d1_indep) else $error("second comparator missed");

    // Mask role widens the first comparator over every masked address bit
    property p_d_mask;
        @(posedge hclk) disable iff (!hresetn)
        (dacc.valid && !dacc.is_preload && !dacc.is_cp_maint && mask_role &&
         first_comparator_enable == hbu_pkg::HBU_ACC_ANY && dacc.addr[1:0] == 2'b00 &&
         dacc.size <= 3'd2 && ((dacc.addr ^ dba0_reg) & ~dba1_reg) == hbu_pkg::REG_RESET)
        |=> data_exc.req;
    endproperty
    a_d_mask: assert property (p_d_mask) else $error("masked address missed");

    ////////////////////////////////////////////////////////////////////////
    // Exception requests to the core
    logic sw_take;
    assign sw_take = sw_break_valid && global_debug_enable;

    // Instruction side: breakpoint before execute, software breakpoint otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_exc <= '0;
            sw_break_nop <= 1'b0;
        end else begin
            instr_exc.req <= (|ib_hit) || sw_take;
            instr_exc.cause <= (|ib_hit) ? hbu_pkg::CAUSE_IBRK :
                               (sw_take ? hbu_pkg::CAUSE_SBRK : hbu_pkg::CAUSE_NONE);
            instr_exc.prio <= (|ib_hit) ? hbu_pkg::PRIO_IBRK : hbu_pkg::PRIO_SBRK;
            instr_exc.as_data_abort <= 1'b0;
            instr_exc.as_prefetch_abort <= monitor_mode && ((|ib_hit) || sw_take);
            instr_exc.link <= fetch_addr + hbu_pkg::LINK_OFS;
            sw_break_nop <= sw_break_valid && !global_debug_enable;
        end
    end

    // Data side: reported after the access, access itself not aborted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_exc <= '0;
        end else begin
            data_exc.req <= d0_hit || d1_hit;
            data_exc.cause <= (d0_hit || d1_hit) ? hbu_pkg::CAUSE_DBRK :
                              hbu_pkg::CAUSE_NONE;
            data_exc.prio <= hbu_pkg::PRIO_DBRK;
            data_exc.as_data_abort <= monitor_mode && (d0_hit || d1_hit);
            data_exc.as_prefetch_abort <= 1'b0;
            data_exc.link <= dacc.next_pc + hbu_pkg::LINK_OFS;
        end
    end

    // Entry cause: data breakpoint outranks instruction breakpoint
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            entry_cause <= hbu_pkg::CAUSE_NONE;
        end else if (d0_hit || d1_hit) begin
            entry_cause <= hbu_pkg::CAUSE_DBRK;
        end else if (|ib_hit) begin
            entry_cause <= hbu_pkg::CAUSE_IBRK;
        end else if (sw_take) begin
            entry_cause <= hbu_pkg::CAUSE_SBRK;
        end
    end

    // Enabled software breakpoint raises a request instead of a no-op
    property p_sw_take;
        @(posedge hclk) disable iff (!hresetn)
        (sw_break_valid && global_debug_enable) |=> instr_exc.req && !sw_break_nop;
    endproperty
    a_sw_take: assert property (p_sw_take) else $error("software break not taken");

    // Lone instruction request leaves its own cause in the entry field
    property p_i_entry;
        @(posedge hclk) disable iff (!hresetn)
        (instr_exc.req && !data_exc.req) |-> entry_cause == instr_exc.cause;
    endproperty
    a_i_entry: assert property (p_i_entry) else $error("entry cause mismatch");

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_ib_pulse;
        @(posedge hclk) disable iff (!hresetn)
        (fetch_valid && ibc_reg[0][0] && !compressed_state &&
         ibc_reg[0][31:2] == fetch_addr[31:2]) |=> instr_exc.req &&
         instr_exc.cause == 3'h1;
    endproperty
    a_ib_pulse: assert property (p_ib_pulse) else $error("ib hit missed");

    property p_ib_off;
        @(posedge hclk) disable iff (!hresetn)
        (!ibc_reg[0][0] && !ibc_reg[1][0] && !sw_break_valid) |=> !instr_exc.req;
    endproperty
    a_ib_off: assert property (p_ib_off) else $error("ib fired disabled");

    property p_sw_nop;
        @(posedge hclk) disable iff (!hresetn)
        (sw_break_valid && !global_debug_enable) |=> sw_break_nop;
    endproperty
    a_sw_nop: assert property (p_sw_nop) else $error("bkpt not nop");

    property p_pref;
        @(posedge hclk) disable iff (!hresetn)
        (dacc.valid && dacc.is_preload) |=> !data_exc.req;
    endproperty
    a_pref: assert property (p_pref) else $error("preload hit");

    property p_swap;
        @(posedge hclk) disable iff (!hresetn)
        (dacc.is_swap && first_comparator_enable == 2'b11 &&
         (second_comparator_enable == 2'b11 || second_comparator_enable == 2'b00 || mask_role))
        |=> !data_exc.req;
    endproperty
    a_swap: assert property (p_swap) else $error("swap as load");

    property p_dcause;
        @(posedge hclk) disable iff (!hresetn)
        data_exc.req |-> data_exc.cause == 3'h2 && entry_cause == 3'h2 &&
        data_exc.link == $past(dacc.next_pc) + 32'h0000_0004;
    endproperty
    a_dcause: assert property (p_dcause) else $error("data cause/link");

    property p_d1_mask;
        @(posedge hclk) disable iff (!hresetn)
        (mask_role && first_comparator_enable == 2'b00) |=> !data_exc.req;
    endproperty
    a_d1_mask: assert property (p_d1_mask) else $error("mask role hit");

    sequence s_wr_ctl;
        addr_phase && hwrite && haddr == 32'h0000_0010;
    endsequence
    property p_ctl_wr;
        @(posedge hclk) disable iff (!hresetn)
        s_wr_ctl ##1 1'b1 |=> dbctl_reg == ($past(hwdata) & 32'h0000_010F);
    endproperty
    a_ctl_wr: assert property (p_ctl_wr) else $error("ctl write lost");

    property p_mon;
        @(posedge hclk) disable iff (!hresetn)
        data_exc.req |-> data_exc.as_data_abort == $past(monitor_mode);
    endproperty
    a_mon: assert property (p_mon) else $error("monitor route");

endmodule

// file: dv/hbu_core_model.sv
// Core pipeline and load/store model that offers fetches and data accesses
module hbu_core_model (
    input wire logic hclk,
    output logic fetch_valid,
    output logic [31:0] fetch_addr,
    output logic compressed_state,
    output logic sw_break_valid,
    output hbu_pkg::hbu_dacc_s dacc,
    input wire hbu_pkg::hbu_exc_s instr_exc,
    input wire hbu_pkg::hbu_exc_s data_exc
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pipeline at time zero
    initial begin
        fetch_valid = 1'b0;
        fetch_addr = 32'h0000_0000;
        compressed_state = 1'b0;
        sw_break_valid = 1'b0;
        dacc = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Offer one fetch or breakpoint instruction, return the answer a cycle later
    task automatic issue_fetch(input logic [31:0] a, input logic comp, input logic sw,
        output hbu_pkg::hbu_exc_s e);
        @(posedge hclk);
        fetch_valid <= ~sw;
        sw_break_valid <= sw;
        fetch_addr <= a;
        compressed_state <= comp;
        @(posedge hclk);
        fetch_valid <= 1'b0;
        sw_break_valid <= 1'b0;
        fetch_addr <= ~a; // Released lines carry no stale address
        #1;
        e = instr_exc;
    endtask

    // Offer one data access for a single cycle; flags are store, swap, preload, maint
    task automatic issue_access(input logic [31:0] a, input logic [2:0] sz,
        input logic [3:0] fl, input logic [3:0] cpr, output hbu_pkg::hbu_exc_s e);
        @(posedge hclk);
        dacc <= {1'b1, a, sz, fl, cpr, 32'h0000_8000};
        @(posedge hclk);
        dacc <= {1'b0, ~a, 3'b111, 4'b0000, ~cpr, 32'h0000_0000};
        #1;
        e = data_exc;
    endtask
endmodule

// file: dv/hbu_top_test.sv
// Self-checking testbench of the hardware breakpoint unit
module hbu_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0000_0000;
    logic global_debug_enable = 1'b0;
    logic monitor_mode = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic fetch_valid;
    logic [31:0] fetch_addr;
    logic compressed_state;
    logic sw_break_valid;
    hbu_pkg::hbu_dacc_s dacc;
    hbu_pkg::hbu_exc_s instr_exc;
    hbu_pkg::hbu_exc_s data_exc;
    hbu_pkg::hbu_exc_s e;
    logic [2:0] entry_cause;
    logic sw_break_nop;
    logic [31:0] q;
    int miscompares = 0;
    int tests_run = 0;

    hbu_top i_hbu_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .global_debug_enable, .monitor_mode,
        .fetch_valid, .fetch_addr, .compressed_state, .sw_break_valid, .dacc, .instr_exc,
        .data_exc, .entry_cause, .sw_break_nop);
    hbu_core_model i_hbu_core_model (.hclk, .fetch_valid, .fetch_addr, .compressed_state,
        .sw_break_valid, .dacc, .instr_exc, .data_exc);

    // Free-running 100 MHz clock
    always #5 hclk = ~hclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One single-word transfer: address phase, then data phase
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic rd(input string name, input logic [31:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(name, q, exp);
        chk("response", 32'(hresp), 32'h0000_0000);
    endtask

    // Compare a breakpoint answer; cause 2 marks a data hit
    task automatic exc_chk(input string name, input logic hit, input logic [2:0] cause,
        input logic [3:0] prio, input logic [31:0] link);
        chk({name, " req"}, 32'(e.req), 32'(hit));
        if (hit) begin
            chk({name, " cause"}, 32'(e.cause), 32'(cause));
            chk({name, " entry"}, 32'(entry_cause), 32'(cause));
            chk({name, " prio"}, 32'(e.prio), 32'(prio));
            chk({name, " link"}, e.link, link);
            chk({name, " abort"}, 32'(cause == 3'h2 ? e.as_data_abort : e.as_prefetch_abort),
                32'(monitor_mode));
            chk({name, " other abort"}, 32'(cause == 3'h2 ? e.as_prefetch_abort : e.as_data_abort),
                32'h0000_0000);
        end
    endtask

    task automatic fch(input logic [31:0] a, input logic comp, input logic hit);
        i_hbu_core_model.issue_fetch(a, comp, 1'b0, e);
        exc_chk("ibrk", hit, 3'h1, 4'h9, a + 32'h0000_0004);
    endtask

    task automatic dat(input logic [31:0] a, input logic [2:0] sz, input logic [3:0] fl,
        input logic [3:0] cpr, input logic hit);
        i_hbu_core_model.issue_access(a, sz, fl, cpr, e);
        exc_chk("dbrk", hit, 3'h2, 4'h4, 32'h0000_8004);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        #100000;
        miscompares++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 5; i++) rd("reset", 32'(4 * i), 32'h0000_0000);
        xfer(32'h0000_0014, 1'b1, 32'hFFFF_FFFF);
        rd("unmapped", 32'h0000_0014, 32'h0000_0000);
        for (int i = 0; i < 4; i++) xfer(32'(4 * i), 1'b1, 32'hA5A5_A5A4 + 32'(i));
        for (int i = 0; i < 4; i++) rd("regrw", 32'(4 * i), 32'hA5A5_A5A4 + 32'(i));
        xfer(32'h0000_0010, 1'b1, 32'hFFFF_FFFF);
        rd("control", 32'h0000_0010, 32'h0000_010F);
        global_debug_enable <= 1'b1;
        xfer(32'h0000_0000, 1'b1, 32'h0000_1001);
        xfer(32'h0000_0004, 1'b1, 32'h0000_2003);
        fch(32'h0000_1000, 1'b0, 1'b1);
        fch(32'h0000_1002, 1'b0, 1'b1);
        fch(32'h0000_1002, 1'b1, 1'b0);
        monitor_mode <= 1'b1;
        fch(32'h0000_2002, 1'b1, 1'b1);
        monitor_mode <= 1'b0;
        xfer(32'h0000_0000, 1'b1, 32'h0000_1000);
        xfer(32'h0000_0004, 1'b1, 32'h0000_2002);
        fch(32'h0000_1000, 1'b0, 1'b0);
        global_debug_enable <= 1'b0;
        i_hbu_core_model.issue_fetch(32'h0000_1000, 1'b0, 1'b1, e);
        chk("swnop", {30'h0, sw_break_nop, e.req}, 32'h0000_0002);
        global_debug_enable <= 1'b1;
        i_hbu_core_model.issue_fetch(32'h0000_1000, 1'b0, 1'b1, e);
        exc_chk("sbrk", 1'b1, 3'h3, 4'hB, 32'h0000_1004);
        xfer(32'h0000_0008, 1'b1, 32'h0000_3000);
        for (int m = 0; m < 4; m++) begin
            xfer(32'h0000_0010, 1'b1, 32'(m));
            dat(32'h0000_3000, 3'd2, 4'b1000, 4'h0, m == 1 || m == 2);
            dat(32'h0000_3000, 3'd2, 4'b0000, 4'h0, m >= 2);
        end
        dat(32'h0000_3000, 3'd2, 4'b0100, 4'h0, 1'b0);
        xfer(32'h0000_0010, 1'b1, 32'h0000_0001);
        dat(32'h0000_3000, 3'd2, 4'b0100, 4'h0, 1'b1);
        xfer(32'h0000_0010, 1'b1, 32'h0000_0002);
        dat(32'h0000_3002, 3'd2, 4'b0000, 4'h0, 1'b1);
        dat(32'h0000_3003, 3'd0, 4'b0000, 4'h0, 1'b0);
        dat(32'h0000_3000, 3'd2, 4'b0010, 4'h0, 1'b0);
        dat(32'h0000_3000, 3'd2, 4'b1001, 4'h7, 1'b0);
        dat(32'h0000_3000, 3'd2, 4'b1001, 4'hA, 1'b0);
        monitor_mode <= 1'b1;
        xfer(32'h0000_0008, 1'b1, 32'h0000_3003);
        dat(32'h0000_3000, 3'd2, 4'b0000, 4'h0, 1'b1);
        monitor_mode <= 1'b0;
        xfer(32'h0000_0008, 1'b1, 32'h0000_3000);
        xfer(32'h0000_000C, 1'b1, 32'h0000_00FF);
        xfer(32'h0000_0010, 1'b1, 32'h0000_010E);
        dat(32'h0000_30F0, 3'd2, 4'b1000, 4'h0, 1'b1);
        xfer(32'h0000_0010, 1'b1, 32'h0000_010C);
        dat(32'h0000_30F0, 3'd2, 4'b0000, 4'h0, 1'b0);
        xfer(32'h0000_000C, 1'b1, 32'h0000_4000);
        xfer(32'h0000_0010, 1'b1, 32'h0000_0004);
        dat(32'h0000_4000, 3'd2, 4'b1000, 4'h0, 1'b1);
        dat(32'h0000_4000, 3'd2, 4'b0000, 4'h0, 1'b0);
        tally_and_finish();
    end
endmodule
